// ==== rtl/ppm_map.vh ====
/*
 * constants of the program page mapper: data-space addresses, field
 * positions, program-space vector areas and sizes.
 * assumes inclusion by its bare name from the mapper module.
 */
// How it works
// - the page select register sits at data address cah and takes whole-byte writes but never answers a read.
// - interrupts, calls and returns leave the page select register untouched.
// - reset does not load the page select register, so it is undefined until first written.
// - with program counter bit 11 set the static page 1 is addressed regardless of the page bits.
// - with program counter bit 11 clear the two low page bits pick page 0, 1, 2 or 3.
// - nmi vector is fetched from 0ffch-0ffdh, reset vector from 0ffeh-0fffh, other vectors from 0ff0h-0ff7h.
// - a 64-byte data-space window shows read-only constants held in program memory.
// - a six-entry stack of 12-bit return addresses serves calls and interrupts.
// - extra ram appears as switchable 64-byte banks at data addresses 00h to 3fh.
// - with readout protection selected no external read of program memory is possible.
// - a window read forms its program address from the window position above six data address bits.
`ifndef PPM_MAP_VH
`define PPM_MAP_VH
`define PPM_PAGE_SEL_ADDR   8'hca
`define PPM_WIN_POS_ADDR    8'hc9
`define PPM_RAM_BANK_ADDR   8'hcb
`define PPM_WIN_BASE        8'h40
`define PPM_WIN_MASK        8'hc0
`define PPM_BANK_TOP        8'h3f
`define PPM_PC_STATIC_BIT   11
`define PPM_STATIC_PAGE     2'h1
`define PPM_BANK1_BIT       3
`define PPM_BANK2_BIT       4
`define PPM_VEC_IRQ_LO      12'hff0
`define PPM_VEC_IRQ_HI      12'hff7
`define PPM_VEC_NMI         12'hffc
`define PPM_VEC_RESET       12'hffe
`define PPM_STACK_DEPTH     6
`endif

// ==== rtl/ppm_mapper.v ====
/*
 * program page mapper: page select register, program address forming,
 * data window reads, ram bank select and the return-address stack.
 * the upper half of program space always shows the static page; the
 * lower half shows whichever page the page select register names.
 * the window, bank and page registers are write-only and keep no reset
 * value, so software must load them before relying on them.
 * stack overflow and underflow are silently dropped; software must keep
 * its nesting within the stack depth.
 * assumes a cpu core issuing one data write or read per cycle strobe and
 * a program memory that answers combinationally on the physical address.
 * assumes the core raises its vector strobes only while fetching a vector
 * and never raises a window read and an external read in one cycle.
 * assumes readout protection is a static option level from option logic.
 * assumes one clock for core and memory; all inputs are synchronous to it.
 */
`timescale 1ns/100ps
`include "ppm_map.vh"
module ppm_mapper #(
    parameter PC_W  = 12,
    parameter PA_W  = 13,
    parameter DEPTH = `PPM_STACK_DEPTH
) (
    input  wire            sys_clk_i,
    input  wire            arst_n_i,
    input  wire [PC_W-1:0] pc_i,
    input  wire            vec_nmi_i,
    input  wire            vec_reset_i,
    input  wire            vec_irq_i,
    input  wire [1:0]      vec_irq_sel_i,
    input  wire            vec_half_i,
    input  wire [7:0]      data_addr_i,
    input  wire [7:0]      data_wdata_i,
    input  wire            data_we_i,
    input  wire            data_re_i,
    input  wire            push_i,
    input  wire            pop_i,
    input  wire [PC_W-1:0] push_addr_i,
    input  wire            readout_protect_i,
    input  wire            ext_read_i,
    input  wire [PA_W-1:0] ext_addr_i,
    input  wire [7:0]      pmem_rdata_i,
    output wire [PA_W-1:0] pmem_addr_o,
    output reg  [7:0]      win_rdata_o,
    output wire            win_hit_o,
    output wire            reg_hit_o,
    output wire            bank_hit_o,
    output wire [1:0]      ram_bank_o,
    output reg  [7:0]      ext_rdata_o,
    output wire [PC_W-1:0] stack_top_o,
    output wire            stack_full_o,
    output wire            stack_empty_o
);

    // page select keeps only the two page bits
    reg  [1:0]      page_sel_r;
    reg  [6:0]      win_pos_r;
    reg  [1:0]      bank_sel_r;
    reg  [PC_W-1:0] stack_r [0:DEPTH-1];
    reg  [2:0]      sp_r;
    reg  [2:0]      sp_nxt;
    reg  [PC_W-1:0] fetch_pc;
    reg  [PA_W-1:0] pmem_addr;
    integer         i;

    // decoded strobes and stack guards
    wire            page_wr;
    wire            win_wr;
    wire            bank_wr;
    wire            win_rd;
    wire            push_ok;
    wire            pop_ok;

    // stack pointer values that bound a push and a pop
    localparam [2:0] SP_EMPTY = 3'h0;
    localparam [2:0] SP_FULL  = DEPTH[2:0];

    // true when a data address hits one byte-wide register location
    function addr_match;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_match = (addr == target);
        end
    endfunction

    // true when a data address falls inside the read-only window
    function in_window;
        input [7:0] addr;
        begin
            in_window = ((addr & `PPM_WIN_MASK) == `PPM_WIN_BASE);
        end
    endfunction

    // page number shown for a logical program address
    function [1:0] page_of;
        input [PC_W-1:0] pc;
        input [1:0]      pg;
        begin
            if (pc[`PPM_PC_STATIC_BIT]) begin
                page_of = `PPM_STATIC_PAGE;
            end else begin
                case (pg)
                    2'h0:    page_of = 2'h0;
                    2'h1:    page_of = `PPM_STATIC_PAGE;
                    2'h2:    page_of = 2'h2;
                    2'h3:    page_of = 2'h3;
                    default: page_of = pg;
                endcase
            end
        end
    endfunction

    // physical address: page number above the eleven in-page bits
    function [PA_W-1:0] phys_addr;
        input [PC_W-1:0] pc;
        input [1:0]      pg;
        begin
            phys_addr = {page_of(pc, pg), pc[10:0]};
        end
    endfunction

    // write and read strobes decoded once, shared by the processes below
    assign page_wr = data_we_i && addr_match(data_addr_i, `PPM_PAGE_SEL_ADDR);
    assign win_wr  = data_we_i && addr_match(data_addr_i, `PPM_WIN_POS_ADDR);
    assign bank_wr = data_we_i && addr_match(data_addr_i, `PPM_RAM_BANK_ADDR);
    assign win_rd  = data_re_i && in_window(data_addr_i);

    // page, window and bank registers load on whole-byte writes only; no reset term
    always @(posedge sys_clk_i) begin
        if (page_wr) begin
            page_sel_r <= data_wdata_i[1:0];
        end
        if (win_wr) begin
            win_pos_r <= data_wdata_i[6:0];
        end
        if (bank_wr) begin
            bank_sel_r <= {data_wdata_i[`PPM_BANK2_BIT], data_wdata_i[`PPM_BANK1_BIT]};
        end
    end
    // nothing but a data write touches page_sel_r

    // vector fetch overrides the program counter with a static-page address
    always @* begin
        fetch_pc = pc_i;
        if (vec_reset_i) begin
            fetch_pc = `PPM_VEC_RESET | {11'h000, vec_half_i};
        end else if (vec_nmi_i) begin
            fetch_pc = `PPM_VEC_NMI | {11'h000, vec_half_i};
        end else if (vec_irq_i) begin
            fetch_pc = `PPM_VEC_IRQ_LO | {9'h000, vec_irq_sel_i, vec_half_i};
        end
    end

    // window reads borrow the memory port, so they take priority over fetch
    always @* begin
        pmem_addr = phys_addr(fetch_pc, page_sel_r);
        if (win_rd) begin
            pmem_addr = {win_pos_r, data_addr_i[5:0]};
        end else if (ext_read_i) begin
            pmem_addr = ext_addr_i;
        end
    end

    assign pmem_addr_o = pmem_addr;

    // combinational hit flags for the core's data-space decoder
    assign win_hit_o  = in_window(data_addr_i);
    assign reg_hit_o  = addr_match(data_addr_i, `PPM_PAGE_SEL_ADDR);
    assign bank_hit_o = (data_addr_i <= `PPM_BANK_TOP);
    assign ram_bank_o = bank_hit_o ? bank_sel_r : 2'h0;

    // registered read data; the page register never drives read data
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            win_rdata_o <= 8'h00;
            ext_rdata_o <= 8'h00;
        end else begin
            if (win_rd) begin
                win_rdata_o <= pmem_rdata_i;
            end
            if (ext_read_i) begin
                ext_rdata_o <= readout_protect_i ? 8'h00 : pmem_rdata_i;
            end
        end
    end

    // push when full and pop when empty are dropped; a taken push wins
    assign push_ok = push_i && (sp_r != SP_FULL);
    assign pop_ok  = pop_i && !push_ok && (sp_r != SP_EMPTY);

    // next stack pointer
    always @* begin
        sp_nxt = sp_r;
        if (push_ok) begin
            sp_nxt = sp_r + 3'h1;
        end else if (pop_ok) begin
            sp_nxt = sp_r - 3'h1;
        end
    end

    // return-address stack storage and pointer
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sp_r <= 3'h0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                stack_r[i] <= {PC_W{1'b0}};
            end
        end else begin
            if (push_ok) begin
                stack_r[sp_r] <= push_addr_i;
            end
            sp_r <= sp_nxt;
        end
    end

    // top entry and level flags for the core
    assign stack_top_o   = (sp_r == SP_EMPTY) ? {PC_W{1'b0}} : stack_r[sp_r - 3'h1];
    assign stack_full_o  = (sp_r == SP_FULL);
    assign stack_empty_o = (sp_r == SP_EMPTY);

endmodule // ppm_mapper

// ==== bench/ppm_mapper_asserts.sv ====
/* port checker of ppm_mapper; assumes a bind from the bench top */
`timescale 1ns/100ps
module ppm_mapper_asserts (
    input wire        sys_clk_i, arst_n_i, vec_nmi_i, vec_reset_i, vec_irq_i, vec_half_i,
    input wire        data_we_i, data_re_i, push_i, readout_protect_i, ext_read_i, stack_full_o,
    input wire [1:0]  vec_irq_sel_i,
    input wire [7:0]  data_addr_i, data_wdata_i, pmem_rdata_i, win_rdata_o, ext_rdata_o,
    input wire [11:0] pc_i, push_addr_i, stack_top_o,
    input wire [12:0] pmem_addr_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // plain fetch: no window, external or vector request
    wire fetch = !data_re_i && !ext_read_i && !vec_nmi_i && !vec_reset_i && !vec_irq_i;
    wire nodata = !data_re_i && !ext_read_i;
    a_static_page: assert property (fetch && pc_i[11] |-> pmem_addr_o == {2'h1, pc_i[10:0]})
        else $error("static page wrong");
    a_page_select: assert property (data_we_i && data_addr_i == 8'hca |=>
        !fetch || pc_i[11] || pmem_addr_o == {$past(data_wdata_i[1:0]), pc_i[10:0]})
        else $error("page select wrong");
    a_reset_vector: assert property (nodata && vec_reset_i |->
        pmem_addr_o == 13'h0ffe + vec_half_i) else $error("reset vector wrong");
    a_nmi_vector: assert property (nodata && vec_nmi_i && !vec_reset_i |->
        pmem_addr_o == 13'h0ffc + vec_half_i) else $error("nmi vector wrong");
    a_irq_vector: assert property (nodata && vec_irq_i && !vec_nmi_i && !vec_reset_i |->
        pmem_addr_o == 13'h0ff0 + {vec_irq_sel_i, vec_half_i}) else $error("irq vector wrong");
    a_window_data: assert property (data_re_i && data_addr_i[7:6] == 2'h1 |=>
        win_rdata_o == $past(pmem_rdata_i)) else $error("window data wrong");
    a_protect_read: assert property (ext_read_i && readout_protect_i && !data_re_i |=>
        ext_rdata_o == 8'h00) else $error("protected read leaked");
    a_stack_push: assert property (push_i && !stack_full_o |=>
        stack_top_o == $past(push_addr_i)) else $error("push not on top");
endmodule // ppm_mapper_asserts

// ==== bench/ppm_pmem_model.sv ====
/* program memory model; assumes a combinational read on the address */
`timescale 1ns/100ps
module ppm_pmem_model (
    input  wire [12:0] addr_i,
    output wire [7:0]  data_o
);
    // pattern mixes the page bits in so pages read apart
    assign data_o = addr_i[7:0] ^ {3'h0, addr_i[12:8]};
endmodule // ppm_pmem_model

// ==== bench/tb.sv ====
/* bench top for ppm_mapper; assumes the memory model and the checker */
`timescale 1ns/100ps
module tb;
    reg         sys_clk_i = 0, arst_n_i = 0, vec_nmi_i = 0, vec_reset_i = 0, vec_irq_i = 0;
    reg         vec_half_i = 0, data_we_i = 0, data_re_i = 0, push_i = 0, pop_i = 0;
    reg         readout_protect_i = 0, ext_read_i = 0;
    reg  [1:0]  vec_irq_sel_i = 0;
    reg  [7:0]  data_addr_i = 0, data_wdata_i = 0;
    reg  [11:0] pc_i = 0, push_addr_i = 0;
    reg  [12:0] ext_addr_i = 0;
    wire [7:0]  pmem_rdata_i, win_rdata_o, ext_rdata_o;
    wire [12:0] pmem_addr_o;
    wire [11:0] stack_top_o;
    wire [1:0]  ram_bank_o;
    wire        win_hit_o, reg_hit_o, bank_hit_o, stack_full_o, stack_empty_o;
    integer     miscompares = 0, n_compared = 0, i;
    ppm_mapper DUT (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .pc_i(pc_i), .vec_nmi_i(vec_nmi_i),
        .vec_reset_i(vec_reset_i), .vec_irq_i(vec_irq_i), .vec_irq_sel_i(vec_irq_sel_i),
        .vec_half_i(vec_half_i), .data_addr_i(data_addr_i), .data_wdata_i(data_wdata_i),
        .data_we_i(data_we_i), .data_re_i(data_re_i), .push_i(push_i), .pop_i(pop_i),
        .push_addr_i(push_addr_i), .readout_protect_i(readout_protect_i),
        .ext_read_i(ext_read_i), .ext_addr_i(ext_addr_i), .pmem_rdata_i(pmem_rdata_i),
        .pmem_addr_o(pmem_addr_o), .win_rdata_o(win_rdata_o), .win_hit_o(win_hit_o),
        .reg_hit_o(reg_hit_o), .bank_hit_o(bank_hit_o), .ram_bank_o(ram_bank_o),
        .ext_rdata_o(ext_rdata_o), .stack_top_o(stack_top_o),
        .stack_full_o(stack_full_o), .stack_empty_o(stack_empty_o)
    );
    ppm_pmem_model u_mem (.addr_i(pmem_addr_o), .data_o(pmem_rdata_i));
    always #4 sys_clk_i = ~sys_clk_i;
    task chk(input [12:0] got, input [12:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // whole-byte write, one idle cycle after it
    task wr(input [7:0] a, input [7:0] d);
        begin
            data_addr_i = a;
            data_wdata_i = d;
            data_we_i = 1;
            @(negedge sys_clk_i) data_we_i = 0;
            @(negedge sys_clk_i);
        end
    endtask
    task complete_run;
        begin
            $display("compared %0d mismatched %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        #5000 miscompares = miscompares + 1;
        complete_run;
    end
    // main sequence, inputs move on falling edges
    initial begin
        #16 arst_n_i = 1;
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'hca, {6'h3f, i[1:0]});
            pc_i = 12'h123;
            @(negedge sys_clk_i) chk(pmem_addr_o, {i[1:0], 11'h123});
            pc_i = 12'h923;
            @(negedge sys_clk_i) chk(pmem_addr_o, 13'h0923);
        end
        {vec_reset_i, vec_half_i} = 2'b11;
        @(negedge sys_clk_i) chk(pmem_addr_o, 13'h0fff);
        {vec_reset_i, vec_nmi_i} = 2'b01;
        @(negedge sys_clk_i) chk(pmem_addr_o, 13'h0ffd);
        {vec_nmi_i, vec_irq_i, vec_irq_sel_i, vec_half_i} = 5'b01110;
        @(negedge sys_clk_i) chk(pmem_addr_o, 13'h0ff6);
        $display("pages and vectors done");
        vec_irq_i = 0;
        pc_i = 12'h456;
        push_i = 1;
        for (i = 0; i < 7; i = i + 1) begin
            push_addr_i = 12'h100 + i[11:0];
            @(negedge sys_clk_i);
        end
        push_i = 0;
        chk(stack_top_o, 13'h0105);
        chk(stack_full_o, 13'h1);
        pop_i = 1;
        repeat (6) @(negedge sys_clk_i);
        pop_i = 0;
        chk(stack_empty_o, 13'h1);
        chk(pmem_addr_o, 13'h1c56);
        // mid-run reset empties the stack but leaves the page register alone
        push_addr_i = 12'h1ab;
        push_i = 1;
        @(negedge sys_clk_i) push_i = 0;
        arst_n_i = 0;
        repeat (2) @(negedge sys_clk_i);
        arst_n_i = 1;
        chk(stack_empty_o, 13'h1);
        chk(pmem_addr_o, 13'h1c56);
        pop_i = 1;
        @(negedge sys_clk_i) pop_i = 0;
        chk(stack_empty_o, 13'h1);
        $display("stack done");
        // shadow copy in data ram first, then the page register itself
        wr(8'h84, 8'h02);
        chk(pmem_addr_o, 13'h1c56);
        wr(8'hca, 8'h02);
        chk(pmem_addr_o, 13'h1456);
        wr(8'hc9, 8'h28);
        data_addr_i = 8'h59;
        data_re_i = 1;
        #1 chk(pmem_addr_o, 13'h0a19);
        chk(win_hit_o, 13'h1);
        @(negedge sys_clk_i) data_re_i = 0;
        chk(win_rdata_o, 13'h13);
        data_addr_i = 8'hca;
        data_re_i = 1;
        @(negedge sys_clk_i) data_re_i = 0;
        chk(reg_hit_o, 13'h1);
        chk(win_rdata_o, 13'h13);
        wr(8'hcb, 8'h10);
        data_addr_i = 8'h20;
        @(negedge sys_clk_i) chk(ram_bank_o, 13'h2);
        chk(bank_hit_o, 13'h1);
        chk(win_hit_o, 13'h0);
        wr(8'hcb, 8'h08);
        data_addr_i = 8'h3f;
        @(negedge sys_clk_i) chk(ram_bank_o, 13'h1);
        data_addr_i = 8'h40;
        @(negedge sys_clk_i) chk(ram_bank_o, 13'h0);
        chk(bank_hit_o, 13'h0);
        ext_addr_i = 13'h1234;
        ext_read_i = 1;
        @(negedge sys_clk_i) chk(ext_rdata_o, 13'h26);
        readout_protect_i = 1;
        @(negedge sys_clk_i) chk(ext_rdata_o, 13'h0);
        ext_read_i = 0;
        readout_protect_i = 0;
        $display("window and readout done");
        complete_run;
    end
endmodule // tb
bind ppm_mapper ppm_mapper_asserts u_chk (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .vec_nmi_i(vec_nmi_i),
    .vec_reset_i(vec_reset_i), .vec_irq_i(vec_irq_i), .vec_half_i(vec_half_i),
    .data_we_i(data_we_i), .data_re_i(data_re_i), .push_i(push_i),
    .readout_protect_i(readout_protect_i), .ext_read_i(ext_read_i),
    .stack_full_o(stack_full_o), .vec_irq_sel_i(vec_irq_sel_i), .data_addr_i(data_addr_i),
    .data_wdata_i(data_wdata_i), .pmem_rdata_i(pmem_rdata_i), .win_rdata_o(win_rdata_o),
    .ext_rdata_o(ext_rdata_o), .pc_i(pc_i), .push_addr_i(push_addr_i),
    .stack_top_o(stack_top_o), .pmem_addr_o(pmem_addr_o)
);
